// >>> rtl/ept_pkg.sv
package ept_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] EPT_OFS_CTRL    = 4'h0;
  localparam logic [3:0] EPT_OFS_PRELOAD = 4'h4;
  localparam logic [3:0] EPT_OFS_COUNT   = 4'h8;
  localparam logic [3:0] EPT_OFS_SYS     = 4'hC;
  // control register field positions
  localparam int EPT_CTRL_PSC_LSB = 0;
  localparam int EPT_CTRL_EDGE    = 3;
  localparam int EPT_CTRL_RUN     = 4;
  localparam int EPT_CTRL_MODE_LSB = 6;
  // system register field positions
  localparam int EPT_SYS_TIE     = 0;
  localparam int EPT_SYS_IRQF    = 1;
  localparam int EPT_SYS_PDOWN   = 2;
  localparam int EPT_SYS_DIR_TMR = 3;
  localparam int EPT_SYS_DIR_B0  = 4;
  localparam int EPT_SYS_DIR_B1  = 5;
  localparam int EPT_SYS_DAT_B0  = 6;
  localparam int EPT_SYS_DAT_B1  = 7;
  localparam int EPT_SYS_TONE_EN = 8;
  // reset values and the counter full value
  localparam logic [7:0] EPT_CTRL_RST    = 8'h00;
  localparam logic [7:0] EPT_COUNT_RST   = 8'h00;
  localparam logic [7:0] EPT_PRELOAD_RST = 8'h00;
  localparam logic [8:0] EPT_SYS_RST     = 9'h0F8;
  localparam logic [7:0] EPT_COUNT_FULL  = 8'hFF;
  // operating mode field encodings
  localparam logic [1:0] EPT_MODE_EVENT = 2'h1;
  localparam logic [1:0] EPT_MODE_TIMER = 2'h2;
  localparam logic [1:0] EPT_MODE_PULSE = 2'h3;
  // pulse measurement phase
  typedef enum logic [1:0] {EPT_PW_IDLE, EPT_PW_ARMED, EPT_PW_COUNT}
    ept_pw_state_t;
  // shared port lines toward the pad ring
  typedef struct packed {
    logic tone_true;
    logic tone_true_oe_n;
    logic tone_inv;
    logic tone_inv_oe_n;
  } ept_tone_pins_t;
endpackage : ept_pkg

// >>> rtl/ept_timer.sv
// Behaviour
// - event mode counts external pin edges directly
// - counter runs only while run bit set
// - edge select low rising, high falling
// - overflow requests irq, reloads preload, continues
// - interrupt gated by interrupt enable bit
// - pin is timer input for mode and input
// - event counting continues in power-down, wakes
// - pulse mode uses prescaled system clock
// - pulse mode waits for active pin edge
// - edge low: count falling until high, stop
// - edge high: count rising until low, stop
// - timer and event modes never clear run
// - after auto-stop hold count, ignore pin
// - pulse mode starts on transitions, not levels
// - prescaler affects internal clock only
// - each overflow toggles tone output pair
// - second tone output is inverted while data bit zero set
// - tone function needs static configuration option
// - tone output only on output-direction pins
// - port data zero gates tone, one ignored
// - pull-high stays on while pin is input
// - count to FFH, overflow on next increment
// - stopped preload write loads counter too
// - mode field sits at bits 7 and 6
`timescale 1ns/100ps
`default_nettype none
module ept_timer
  import ept_pkg::*;
(
  // clock and reset
  input  wire  logic        clk_sys,
  input  wire  logic        rst_n,
  // avalon-mm slave
  input  wire  logic [3:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [31:0] avs_writedata,
  input  wire  logic [3:0]  avs_byteenable,
  output var   logic [31:0] avs_readdata,
  output var   logic        avs_waitrequest,
  // shared timer pin
  input  wire  logic        timer_pin_in,
  output var   logic        timer_pull_en,
  // tone pins
  input  wire  logic        tone_option_en,
  output var   ept_tone_pins_t tone_pins,
  // interrupt controller and power control
  output var   logic        timer_irq,
  output var   logic        wake_req
);

  // state held across cycles
  logic [7:0]    ctrl_q;
  logic [7:0]    preload_q;
  logic [7:0]    count_q;
  logic [8:0]    sys_q;
  logic [2:0]    pin_sync_q;
  logic          pin_lvl_q;
  logic [6:0]    psc_q;
  logic          tone_q;
  logic          ack_q;
  ept_pw_state_t pw_q;

  // decoded fields, pin edges, enables and bus strobes
  logic [1:0] mode;
  logic       run;
  logic       edge_hi;
  logic       pin_is_input;
  logic       pin_rise;
  logic       pin_fall;
  logic       act_edge;
  logic       back_edge;
  logic       tick_int;
  logic       tick;
  logic       ovf;
  logic       wr_ctrl;
  logic       wr_pre;
  logic       wr_sys;
  logic       wr_cnt;
  logic       pw_stop;
  logic       psc_tick;
  logic       lead_edge;
  logic [31:0] rd_mux;

  // control fields; software should set the mode before raising run,
  // a single write that changes both starts in the new mode at once
  assign mode    = ctrl_q[EPT_CTRL_MODE_LSB +: 2];
  assign run     = ctrl_q[EPT_CTRL_RUN];
  assign edge_hi = ctrl_q[EPT_CTRL_EDGE];

  // single-cycle strobes in the cycle waitrequest is low, so a write
  // lands on the very edge at which the master sees its answer; the
  // master still holds address and data there
  // lanes above zero are ignored by the 8-bit registers
  assign wr_ctrl = avs_write && ack_q && avs_address == EPT_OFS_CTRL
                   && avs_byteenable[0];
  assign wr_pre  = avs_write && ack_q && avs_address == EPT_OFS_PRELOAD
                   && avs_byteenable[0];
  assign wr_cnt  = avs_write && ack_q && avs_address == EPT_OFS_COUNT
                   && avs_byteenable[0];
  assign wr_sys  = avs_write && ack_q && avs_address == EPT_OFS_SYS;

  // the pin counts as a timer input only in an external mode as input
  // with the pin as output, or in timer mode, edges are dropped here
  assign pin_is_input = sys_q[EPT_SYS_DIR_TMR] &&
                        (mode == EPT_MODE_EVENT ||
                         mode == EPT_MODE_PULSE);

  // three-stage synchroniser, edge only when stages two and three agree
  // reset to the pulled-up idle level so no false edge follows reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 3'h7;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], timer_pin_in};
    end
  end

  // settled pin level, updated once stages two and three agree
  // a glitch that shows in one stage only never reaches this level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_lvl_q <= 1'b1;
    end else if (pin_sync_q[1] == pin_sync_q[2]) begin
      pin_lvl_q <= pin_sync_q[2];
    end
  end

  assign pin_rise = pin_is_input && (pin_sync_q[1] == pin_sync_q[2])
                    && pin_sync_q[2] && !pin_lvl_q;
  assign pin_fall = pin_is_input && (pin_sync_q[1] == pin_sync_q[2])
                    && !pin_sync_q[2] && pin_lvl_q;
  // event mode counts the selected edge; pulse mode starts on the
  // leading edge and stops on the trailing one, the event edge again
  assign act_edge  = edge_hi ? pin_fall : pin_rise;
  assign lead_edge = edge_hi ? pin_rise : pin_fall;
  assign back_edge = edge_hi ? pin_fall : pin_rise;

  // prescaler: free 7-bit divider, ratio 2^psc on the system clock
  // it never stops, so the first period after run may be short by up
  // to one prescaled clock; traded for a divider with no restart path
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      psc_q <= 7'h00;
    end else begin
      psc_q <= psc_q + 7'h01;
    end
  end

  // one-cycle enable when the low psc bits of the divider wrap
  // a ratio of zero gives a tick on every system clock
  always_comb begin
    psc_tick = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(ctrl_q[EPT_CTRL_PSC_LSB +: 3]) && !psc_q[i]) begin
        psc_tick = 1'b0;
      end
    end
  end
  assign tick_int = psc_tick;

  // pulse-mode end: pin went back to its idle level; the trailing
  // edge cycle itself is not counted
  assign pw_stop = (pw_q == EPT_PW_COUNT) &&
                   back_edge;

  // count enable by mode; event mode is independent of power-down
  // mode 00 is not a counting mode and holds the counter still
  // pulse mode counts only between its two edges
  always_comb begin
    tick = 1'b0;
    if (run) begin
      case (mode)
        EPT_MODE_EVENT: tick = act_edge;
        EPT_MODE_TIMER: tick = tick_int;
        EPT_MODE_PULSE: tick = (pw_q == EPT_PW_COUNT) && !pw_stop
                               && tick_int;
        default:        tick = 1'b0;
      endcase
    end
  end
  assign ovf = tick && (count_q == EPT_COUNT_FULL);

  // pulse phase tracking, edge-driven only
  // arming takes one cycle after run, so an edge already past is not
  // taken as a start; dropping run or leaving the mode disarms at once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pw_q <= EPT_PW_IDLE;
    end else begin
      case (pw_q)
        EPT_PW_IDLE: begin
          if (run && mode == EPT_MODE_PULSE) begin
            pw_q <= EPT_PW_ARMED;
          end
        end
        EPT_PW_ARMED: begin
          // a pin already active does not start: needs a transition
          if (!run || mode != EPT_MODE_PULSE) begin
            pw_q <= EPT_PW_IDLE;
          end else if (lead_edge) begin
            pw_q <= EPT_PW_COUNT;
          end
        end
        EPT_PW_COUNT: begin
          if (!run || mode != EPT_MODE_PULSE || pw_stop) begin
            pw_q <= EPT_PW_IDLE;
          end
        end
        default: pw_q <= EPT_PW_IDLE;
      endcase
    end
  end

  // control register; hardware clears run only at pulse end
  // a software write in the same cycle wins, it is the newer intent
  // timer and event modes never reach the clear branch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= EPT_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= avs_writedata[7:0];
    end else if (pw_stop && mode == EPT_MODE_PULSE) begin
      ctrl_q[EPT_CTRL_RUN] <= 1'b0;
    end
  end

  // preload register
  // holds the reload value; unchanged by overflow
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      preload_q <= EPT_PRELOAD_RST;
    end else if (wr_pre) begin
      preload_q <= avs_writedata[7:0];
    end
  end

  // counter: reload on overflow, direct load when stopped
  // a preload write while running waits for the next overflow
  // a direct count write beats a tick in the same cycle, that tick is
  // lost: software must allow for one count of error there
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= EPT_COUNT_RST;
    end else if (wr_pre && !run) begin
      count_q <= avs_writedata[7:0];
    end else if (wr_cnt) begin
      count_q <= avs_writedata[7:0];
    end else if (ovf) begin
      count_q <= preload_q;
    end else if (tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  // system bits; overflow set wins over a software clear
  // the later assignment below is what gives the set its priority,
  // so a clear in the overflow cycle never loses a request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_q <= EPT_SYS_RST;
    end else begin
      if (wr_sys) begin
        if (avs_byteenable[0]) begin
          sys_q[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          sys_q[8] <= avs_writedata[8];
        end
      end
      if (ovf) begin
        sys_q[EPT_SYS_IRQF] <= 1'b1;
      end
    end
  end

  // interrupt request and wake-up outputs
  // the request is a level until software clears the flag; the wake
  // pulse ignores the enable, so a masked overflow still wakes
  // clearing run before power-down is the way to avoid that
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
      wake_req  <= 1'b0;
    end else begin
      timer_irq <= (sys_q[EPT_SYS_IRQF] || ovf) &&
                   sys_q[EPT_SYS_TIE];
      wake_req  <= ovf && sys_q[EPT_SYS_PDOWN];
    end
  end

  // tone divider toggles on each overflow
  // tone frequency is half the overflow rate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tone_q <= 1'b0;
    end else if (ovf) begin
      tone_q <= !tone_q;
    end
  end

  // tone pins: option, direction and data-zero gating
  // each pin drives only when the option is on and its direction is
  // output; a pin left as input stays free for ordinary use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tone_pins <= '{1'b0, 1'b1, 1'b0, 1'b1};
      timer_pull_en <= 1'b0;
    end else begin
      // data bit one is left out on purpose, it never gates the pair
      tone_pins.tone_true <= sys_q[EPT_SYS_DAT_B0] && tone_q;
      tone_pins.tone_inv  <= sys_q[EPT_SYS_DAT_B0] && !tone_q;
      tone_pins.tone_true_oe_n <= !(tone_option_en &&
                                    !sys_q[EPT_SYS_DIR_B0]);
      tone_pins.tone_inv_oe_n  <= !(tone_option_en &&
                                    !sys_q[EPT_SYS_DIR_B1]);
      timer_pull_en <= sys_q[EPT_SYS_DIR_TMR];
    end
  end

  // read mux; unmapped offsets and unused upper bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      EPT_OFS_CTRL:    rd_mux = {24'h00_0000, ctrl_q};
      EPT_OFS_PRELOAD: rd_mux = {24'h00_0000, preload_q};
      EPT_OFS_COUNT:   rd_mux = {24'h00_0000, count_q};
      EPT_OFS_SYS:     rd_mux = {23'h00_0000, sys_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // avalon answer: one wait cycle, then ack with read data
  // read data is caught at the taking edge and stands until the next
  // read, so the master takes it where it sees waitrequest low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      if (avs_read && !ack_q) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // waitrequest high except the cycle the answer is ready
  // registered, so it is low exactly one cycle after the taking edge
  // and never low twice in a row, whatever the master does
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

endmodule : ept_timer
`default_nettype wire

// >>> tb/ept_src.sv
`timescale 1ns/100ps
`default_nettype none
// pulse source on the timer pin, tone load on the outputs
module ept_src
  import ept_pkg::*;
(
  // clock
  input  wire logic           clk_sys,
  // tone load
  input  wire ept_tone_pins_t tone_pins,
  // pulse source
  output var  logic           pin
);
  logic lvl_q = 1'b1;
  logic prev_q = 1'b0;
  int   n_tog = 0;
  // always driven, so the pull-up never decides the level
  assign pin = lvl_q;
  // load counts every change of the true tone line
  always @(posedge clk_sys) begin
    if (tone_pins.tone_true !== prev_q) n_tog++;
    prev_q <= tone_pins.tone_true;
  end
  // hold a level for n clocks, changed just after an edge
  task automatic hold(input logic lvl, input int n);
    lvl_q <= lvl;
    repeat (n) @(posedge clk_sys);
  endtask : hold
endmodule : ept_src
`default_nettype wire

// >>> tb/ept_timer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ept_chk
  import ept_pkg::*;
(
  // clock and reset
  input wire logic           clk_sys,
  input wire logic           rst_n,
  // register bus
  input wire logic [3:0]     avs_address,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic [31:0]    avs_writedata,
  input wire logic [3:0]     avs_byteenable,
  input wire logic [31:0]    avs_readdata,
  input wire logic           avs_waitrequest,
  // pins
  input wire logic           timer_pin_in,
  input wire logic           timer_pull_en,
  input wire logic           tone_option_en,
  input wire ept_tone_pins_t tone_pins,
  input wire logic           timer_irq,
  input wire logic           wake_req
);
  logic [8:0] s_q;
  logic       live_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // system register shadow, caught at the answering edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q    <= EPT_SYS_RST;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      if (avs_write && !avs_waitrequest && avs_address == EPT_OFS_SYS)
        s_q <= avs_writedata[8:0];
    end
  end
  property p_wait;
    !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait low twice");
  property p_pair;
    tone_option_en && $past(tone_option_en) && s_q[6] && $past(s_q[6])
      |-> tone_pins.tone_inv != tone_pins.tone_true; endproperty
  a_pair: assert property (p_pair) else $error("tone not inverse");
  property p_opt;
    !tone_option_en && !$past(tone_option_en)
      |-> tone_pins.tone_true_oe_n && tone_pins.tone_inv_oe_n; endproperty
  a_opt: assert property (p_opt) else $error("tone drives unset");
  property p_dir;
    s_q[5] && $past(s_q[5]) |-> tone_pins.tone_inv_oe_n; endproperty
  a_dir: assert property (p_dir) else $error("input pin driven");
  property p_gate;
    !s_q[6] && !$past(s_q[6])
      |-> !tone_pins.tone_true && !tone_pins.tone_inv; endproperty
  a_gate: assert property (p_gate) else $error("tone not gated");
  property p_pull;
    live_q && s_q[3] && $past(s_q[3]) |-> timer_pull_en; endproperty
  a_pull: assert property (p_pull) else $error("pull lost");
  property p_mask;
    !s_q[0] && !$past(s_q[0]) |-> !timer_irq; endproperty
  a_mask: assert property (p_mask) else $error("irq unmasked");
  property p_wake;
    wake_req |-> $past(s_q[2]); endproperty
  a_wake: assert property (p_wake) else $error("wake when awake");
  c_wake: cover property (wake_req);
  c_irq: cover property (timer_irq);
  c_tone: cover property ($rose(tone_pins.tone_true));
endmodule : ept_chk

bind ept_timer ept_chk chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer_pin_in(timer_pin_in), .timer_pull_en(timer_pull_en),
  .tone_option_en(tone_option_en), .tone_pins(tone_pins),
  .timer_irq(timer_irq), .wake_req(wake_req)
);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ept_pkg::*;
;
  logic           clk_sys = 1'b0;
  logic           rst_n = 1'b0;
  logic [3:0]     adr = 4'h0;
  logic           rd = 1'b0;
  logic           wr = 1'b0;
  logic [31:0]    wd = 32'h0;
  logic [31:0]    rdat;
  logic           wreq;
  logic           pin;
  logic           opt = 1'b0;
  logic           irq;
  logic           wake;
  logic           woke = 1'b0;
  ept_tone_pins_t tp;
  logic [31:0]    rq;
  int             errors = 0;
  int             n_checks = 0;

  ept_timer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .timer_pin_in(pin), .timer_pull_en(), .tone_option_en(opt),
    .tone_pins(tp), .timer_irq(irq), .wake_req(wake));
  ept_src src_u (.clk_sys(clk_sys), .tone_pins(tp), .pin(pin));

  initial forever #4 clk_sys = ~clk_sys;
  // wake is a one-cycle pulse, so latch it
  always @(posedge clk_sys) if (wake === 1'b1) woke <= 1'b1;

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // window compare, pin sync blurs each edge by a cycle
  task automatic chk_rng(input string s, input int lo, input int hi,
                         input logic [31:0] g);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errors++;
      $display("ERROR %s exp %0d..%0d got %0d", s, lo, hi, g);
    end
  endtask : chk_rng
  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    adr <= a;
    wr  <= w;
    rd  <= !w;
    wd  <= d;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wreq !== 1'b0 && i < 40);
    if (wreq !== 1'b0) begin
      errors++;
      conclude;
    end
    rq = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wait_irq(output int i);
    i = 0;
    while (irq !== 1'b1) begin
      @(posedge clk_sys);
      i++;
      if (i > 100) begin
        errors++;
        conclude;
      end
    end
  endtask : wait_irq
  task automatic t_reset;
    bus(0, EPT_OFS_SYS, 0);
    chk("sys", {23'h0, EPT_SYS_RST}, rq);
    bus(1, 4'h2, 32'hFF);
    bus(0, 4'h2, 0);
    chk("unmapped", 0, rq);
  endtask : t_reset
  task automatic t_timer;
    int i;
    int t0;
    bus(1, EPT_OFS_PRELOAD, 32'hF0);
    bus(0, EPT_OFS_COUNT, 0);
    chk("load", 32'hF0, rq);
    opt <= 1'b1;
    bus(1, EPT_OFS_SYS, 32'hC9);
    t0 = src_u.n_tog;
    bus(1, EPT_OFS_CTRL, 32'h90);
    wait_irq(i);
    chk_rng("ovf", 13, 19, i);
    repeat (2) @(posedge clk_sys);
    chk("tone", t0 + 1, src_u.n_tog);
    chk("pair", 1, tp.tone_true ^ tp.tone_inv);
    bus(0, EPT_OFS_CTRL, 0);
    chk("run", 32'h90, rq);
    bus(1, EPT_OFS_SYS, 32'h89);
    repeat (3) @(posedge clk_sys);
    chk("gate", 0, {tp.tone_true, tp.tone_inv});
    bus(1, EPT_OFS_CTRL, 0);
  endtask : t_timer
  task automatic t_event;
    bus(1, EPT_OFS_SYS, 32'hCC);
    bus(1, EPT_OFS_COUNT, 0);
    src_u.hold(0, 8);
    bus(1, EPT_OFS_CTRL, 32'h50);
    repeat (5) begin
      src_u.hold(1, 6);
      src_u.hold(0, 6);
    end
    bus(0, EPT_OFS_COUNT, 0);
    chk("rise", 5, rq);
    bus(1, EPT_OFS_COUNT, 32'hFE);
    bus(1, EPT_OFS_CTRL, 32'h5F);
    repeat (3) begin
      src_u.hold(1, 6);
      src_u.hold(0, 6);
    end
    bus(0, EPT_OFS_COUNT, 0);
    chk("fall", 32'hF1, rq);
    chk("wake", 1, woke);
    chk("mask", 0, irq);
    bus(0, EPT_OFS_CTRL, 0);
    chk("keep", 32'h5F, rq);
    bus(1, EPT_OFS_CTRL, 0);
  endtask : t_event
  // pin sits at the active level when armed, so no start
  task automatic t_pulse(input logic e, input int w);
    logic [31:0] c;
    c = e ? 32'hD8 : 32'hD0;
    bus(1, EPT_OFS_COUNT, 0);
    src_u.hold(e, 8);
    bus(1, EPT_OFS_CTRL, c);
    src_u.hold(!e, 10);
    bus(0, EPT_OFS_COUNT, 0);
    chk("armed", 0, rq);
    src_u.hold(e, w);
    src_u.hold(!e, 10);
    bus(0, EPT_OFS_CTRL, 0);
    chk("stop", c & 32'hEF, rq);
    bus(0, EPT_OFS_COUNT, 0);
    chk_rng("width", w - 2, w + 2, rq);
    c = rq;
    src_u.hold(e, w);
    src_u.hold(!e, 10);
    bus(0, EPT_OFS_COUNT, 0);
    chk("held", c, rq);
  endtask : t_pulse

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_timer;
    t_event;
    t_pulse(1'b0, 20);
    t_pulse(1'b1, 12);
    conclude;
  end
endmodule : tb_top
`default_nettype wire
